// ===== eprom_program_verify_port_tb.sv
// Testbench: entry, erase, signature, no port 0 drive at write pin settings, program and verify.
// Assumes epv_pkg, epv_port and epv_prog_model are compiled first.
`timescale 1ns/10ps

module eprom_program_verify_port_tb;
	localparam logic [7:0] MAKER  = 8'h3c; // Arbitrary value
	localparam logic [7:0] DEVICE = 8'hc3; // Arbitrary value
	logic        clock;
	logic        srst;
	logic        erase;
	logic        rst_pin;
	logic        strobe;
	logic        pulse_pin;
	logic        supply;
	logic [12:0] addr;
	logic [7:0]  data;
	logic [3:0]  pins;
	logic [7:0]  port0_out;
	logic        port0_oe;
	logic        prog_mode;
	logic        erase_busy;
	logic        write_done;
	wire  [7:0]  port0_bus;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          done_cnt = 0;

	assign port0_bus = port0_oe ? port0_out : 8'hff;

	epv_prog_model m (.clock(clock), .rst_pin(rst_pin), .strobe(strobe), .pulse_pin(pulse_pin),
		.supply(supply), .addr(addr), .data(data), .pins(pins));

	epv_port #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) dut (.clock(clock), .srst(srst),
		.device_reset(rst_pin), .program_fetch_strobe(strobe),
		.latch_and_program_pulse(pulse_pin), .external_access_and_program_supply(supply),
		.port1_in(addr[7:0]), .port2_addr_in(addr[12:8]), .mode_pin_upper_a(pins[3]),
		.mode_pin_upper_b(pins[2]), .mode_pin_lower_a(pins[1]), .mode_pin_lower_b(pins[0]),
		.port0_in(data), .erase(erase), .port0_out(port0_out), .port0_oe(port0_oe),
		.prog_mode(prog_mode), .erase_busy(erase_busy), .write_done(write_done));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) begin
		if (write_done === 1'b1) begin
			done_cnt <= done_cnt + 1;
		end
	end

	task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			error_cnt++;
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (erase_busy !== lvl) begin
			@(posedge clock);
			#1;
			n++;
			if (n > lim) begin
				$display("mismatch erase_busy expected %b seen %b", lvl, erase_busy);
				error_cnt++;
				tally_and_finish();
			end
		end
	endtask

	// Reads one byte as seen on the pulled-up port 0, with its enable
	task automatic read(input logic [12:0] a, input logic [3:0] p, input logic [8:0] exp);
		m.setup(a, 8'h00, p, 1'b0);
		repeat (2) @(posedge clock);
		#1;
		check("port0", exp, {port0_oe, port0_bus});
	endtask

	task automatic t_entry_erase();
		m.enter();
		repeat (2) @(posedge clock);
		#1;
		check("prog_mode", 9'h001, {8'h00, prog_mode});
		@(posedge clock);
		erase <= 1'b1;
		wait_busy(1'b1, 20);
		@(posedge clock);
		erase <= 1'b0;
		wait_busy(1'b0, 9000);
		read(13'h0123, epv_pkg::PINS_VERIFY, 9'h1ff);
		read(13'h1fff, epv_pkg::PINS_VERIFY, 9'h1ff);
		$display("test entry_erase done");
	endtask

	task automatic t_signature();
		read(13'h0030, epv_pkg::PINS_SIGNATURE, {1'b1, MAKER});
		read(13'h0031, epv_pkg::PINS_SIGNATURE, {1'b1, DEVICE});
		read(13'h0003, epv_pkg::PINS_PROG_KEY, 9'h0ff);
		read(13'h0000, epv_pkg::PINS_PROG_SEC1, 9'h0ff);
		$display("test signature done");
	endtask

	// A short first pulse must not count, so 24 good ones leave the write open
	task automatic t_program();
		m.setup(13'h0123, 8'h96, epv_pkg::PINS_PROG_CODE, 1'b1);
		m.pulse(100);
		repeat (24) m.pulse(2000);
		check("write_done count", 9'h000, 9'(done_cnt));
		m.pulse(2000);
		repeat (4) @(posedge clock);
		#1;
		check("write_done count", 9'h001, 9'(done_cnt));
		read(13'h0123, epv_pkg::PINS_VERIFY, {1'b1, ~(8'h96 ^ 8'hff)});
		$display("test program done");
	endtask

	initial begin
		srst = 1'b1;
		erase = 1'b0;
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		t_entry_erase();
		t_signature();
		t_program();
		tally_and_finish();
	end
endmodule

// ===== epv_port.sv
// Device-side program/verify port of the on-chip program EPROM.
// Assumes all pins synchronous to the 20 MHz clock; srst stands for power-up.
`timescale 1ns/10ps

// Function
// - Address comes from ports 1 and 2, code byte from port 0.
// - Any security bit blocks code and table writes, not the other bit.
// - Verify readout on port 0 only while security bit 2 is unprogrammed.
// - Verify data is program byte XNOR encryption table byte.
// - The encryption table has no read mode of its own; verify at a location holding FFH returns the table byte unchanged.
// - Signature bytes read at 030H and 031H with all four mode pins low.
// - Erasure leaves every program array bit at one.
module epv_port #(
	parameter logic [7:0] MAKER_CODE  = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'ha5  // Arbitrary value
) (
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       device_reset,
	input  wire logic       program_fetch_strobe,
	input  wire logic       latch_and_program_pulse,
	input  wire logic       external_access_and_program_supply,
	input  wire logic [7:0] port1_in,
	input  wire logic [4:0] port2_addr_in,
	input  wire logic       mode_pin_upper_a,
	input  wire logic       mode_pin_upper_b,
	input  wire logic       mode_pin_lower_a,
	input  wire logic       mode_pin_lower_b,
	input  wire logic [7:0] port0_in,
	input  wire logic       erase,
	output logic [7:0]      port0_out,
	output logic            port0_oe,
	output logic            prog_mode,
	output logic            erase_busy,
	output logic            write_done
);
	logic [7:0]                  mem [epv_pkg::MEM_DEPTH];
	logic [7:0]                  key [epv_pkg::KEY_DEPTH];
	logic [1:0]                  sec_q;
	logic                        first_q;
	logic                        first_d;
	logic                        armed_q;
	logic                        armed_d;
	logic                        prog_q;
	logic                        prog_d;
	logic                        ers_q;
	logic                        ers_d;
	logic [epv_pkg::ADDR_W-1:0]  ers_addr_q;
	logic [epv_pkg::ADDR_W-1:0]  ers_addr_d;
	logic [7:0]                  p0_q;
	logic [7:0]                  p0_d;
	logic                        oe_q;
	logic                        oe_d;
	logic [25:0]                 snap_q;
	logic [25:0]                 snap;
	logic [3:0]                  pins;
	logic [epv_pkg::ADDR_W-1:0]  addr;
	epv_pkg::epv_mode_e          mode;
	logic                        wr_mode;
	logic                        seq_done;
	logic                        wr_done_q;

	assign pins       = {mode_pin_upper_a, mode_pin_upper_b, mode_pin_lower_a, mode_pin_lower_b};
	assign addr       = {port2_addr_in, port1_in};
	assign snap       = {addr, port0_in, pins, external_access_and_program_supply};
	assign port0_out  = p0_q;
	assign port0_oe   = oe_q;
	assign prog_mode  = prog_q;
	assign erase_busy = ers_q;
	assign write_done = wr_done_q;

	// Mode decode from pin levels and the supply level
	always_comb begin
		mode = epv_pkg::EPV_MD_NONE;
		if (external_access_and_program_supply) begin
			unique case (pins)
				epv_pkg::PINS_PROG_CODE: mode = epv_pkg::EPV_MD_CODE;
				epv_pkg::PINS_PROG_KEY:  mode = epv_pkg::EPV_MD_KEY;
				epv_pkg::PINS_PROG_SEC1: mode = epv_pkg::EPV_MD_SEC1;
				epv_pkg::PINS_PROG_SEC2: mode = epv_pkg::EPV_MD_SEC2;
				default:                 mode = epv_pkg::EPV_MD_NONE;
			endcase
		end else if (latch_and_program_pulse) begin
			if (pins == epv_pkg::PINS_VERIFY) begin
				mode = epv_pkg::EPV_MD_VERIFY;
			end else if (pins == epv_pkg::PINS_SIGNATURE) begin
				mode = epv_pkg::EPV_MD_SIG;
			end
		end
	end

	assign wr_mode = prog_q && !ers_q && mode inside {epv_pkg::EPV_MD_CODE, epv_pkg::EPV_MD_KEY,
		epv_pkg::EPV_MD_SEC1, epv_pkg::EPV_MD_SEC2};

	epv_pulse u_pulse (
		.clock      (clock),
		.srst       (srst),
		.enable     (wr_mode),
		.restart    (snap != snap_q),
		.prog_pulse (latch_and_program_pulse),
		.seq_done   (seq_done)
	);

	// Entry, erase sweep and port 0 next state
	always_comb begin
		first_d    = 1'b0;
		armed_d    = first_q ? program_fetch_strobe : armed_q;
		prog_d     = prog_q | (armed_q & ~program_fetch_strobe & device_reset);
		ers_d      = ers_q;
		ers_addr_d = ers_addr_q;
		if (erase && !ers_q) begin
			ers_d      = 1'b1;
			ers_addr_d = '0;
		end else if (ers_q) begin
			ers_addr_d = ers_addr_q + 13'h0001;
			ers_d      = ~(&ers_addr_q);
		end
		p0_d = epv_pkg::ERASED_BYTE;
		oe_d = 1'b0;
		if (prog_q && !ers_q) begin
			unique case (mode)
				epv_pkg::EPV_MD_VERIFY: begin
					if (sec_q[1]) begin
						// Key byte only ever leaves mixed with program data
						p0_d = mem[addr] ~^ key[addr[epv_pkg::KEY_W-1:0]];
						oe_d = 1'b1;
					end
				end
				epv_pkg::EPV_MD_SIG: begin
					oe_d = 1'b1;
					if (addr == epv_pkg::SIG_MAKER_ADDR) begin
						p0_d = MAKER_CODE;
					end else if (addr == epv_pkg::SIG_DEVICE_ADDR) begin
						p0_d = DEVICE_CODE;
					end
				end
				default: begin
					p0_d = epv_pkg::ERASED_BYTE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			first_q    <= 1'b1;
			armed_q    <= 1'b0;
			prog_q     <= 1'b0;
			ers_q      <= 1'b0;
			ers_addr_q <= '0;
			p0_q       <= epv_pkg::ERASED_BYTE;
			oe_q       <= 1'b0;
			snap_q     <= '0;
			wr_done_q  <= 1'b0;
		end else begin
			first_q    <= first_d;
			armed_q    <= armed_d;
			prog_q     <= prog_d;
			ers_q      <= ers_d;
			ers_addr_q <= ers_addr_d;
			p0_q       <= p0_d;
			oe_q       <= oe_d;
			snap_q     <= snap;
			wr_done_q  <= seq_done && wr_mode;
		end
	end

	// Nonvolatile array, table and security bits: only erase and writes touch them
	always_ff @(posedge clock) begin
		if (ers_q) begin
			mem[ers_addr_q] <= epv_pkg::ERASED_BYTE;
			key[ers_addr_q[epv_pkg::KEY_W-1:0]] <= epv_pkg::ERASED_BYTE;
			sec_q <= epv_pkg::SEC_ERASED;
		end else if (seq_done && wr_mode) begin
			unique case (mode)
				epv_pkg::EPV_MD_CODE: begin
					if (&sec_q) begin
						mem[addr] <= port0_in;
					end
				end
				epv_pkg::EPV_MD_KEY: begin
					if (&sec_q) begin
						key[addr[epv_pkg::KEY_W-1:0]] <= port0_in;
					end
				end
				epv_pkg::EPV_MD_SEC1: sec_q[0] <= 1'b0;
				epv_pkg::EPV_MD_SEC2: sec_q[1] <= 1'b0;
				default: sec_q <= sec_q;
			endcase
		end
	end

	a_no_prog_early: assert property (@(posedge clock) disable iff (srst)
		$rose(prog_q) |-> $past(armed_q) && !$past(program_fetch_strobe) && $past(device_reset))
		else $error("programming mode entered without entry sequence");
	a_sec2_blocks_read: assert property (@(posedge clock) disable iff (srst)
		!sec_q[1] && mode == epv_pkg::EPV_MD_VERIFY |=> !oe_q)
		else $error("verify readout while security bit 2 programmed");
	a_verify_xnor: assert property (@(posedge clock) disable iff (srst)
		prog_q && !ers_q && sec_q[1] && mode == epv_pkg::EPV_MD_VERIFY |=>
		oe_q && p0_q == ($past(mem[addr]) ~^ $past(key[addr[epv_pkg::KEY_W-1:0]])))
		else $error("verify data not encrypted program byte");
	a_sig_maker: assert property (@(posedge clock) disable iff (srst)
		prog_q && !ers_q && mode == epv_pkg::EPV_MD_SIG && addr == epv_pkg::SIG_MAKER_ADDR
		|=> oe_q && p0_q == MAKER_CODE)
		else $error("maker code not presented");
	a_code_locked: assert property (@(posedge clock) disable iff (srst)
		seq_done && wr_mode && mode == epv_pkg::EPV_MD_CODE && !(&sec_q)
		|=> mem[$past(addr)] == $past(mem[addr]))
		else $error("code written while locked");
	a_code_write: assert property (@(posedge clock) disable iff (srst)
		seq_done && wr_mode && mode == epv_pkg::EPV_MD_CODE && (&sec_q)
		|=> mem[$past(addr)] == $past(port0_in))
		else $error("code byte not stored");
	a_erase_ones: assert property (@(posedge clock) disable iff (srst)
		ers_q |=> mem[$past(ers_addr_q)] == epv_pkg::ERASED_BYTE)
		else $error("erase left a zero bit");
	a_oe_only_read: assert property (@(posedge clock) disable iff (srst)
		oe_q |-> $past(mode) inside {epv_pkg::EPV_MD_VERIFY, epv_pkg::EPV_MD_SIG})
		else $error("port 0 driven outside a read mode");
	c_write_code: cover property (@(posedge clock) disable iff (srst)
		seq_done && mode == epv_pkg::EPV_MD_CODE);
	c_verify_read: cover property (@(posedge clock) disable iff (srst)
		oe_q && mode == epv_pkg::EPV_MD_VERIFY);
	c_sec_lock: cover property (@(posedge clock) disable iff (srst) $fell(sec_q[1]));
endmodule

// ===== epv_prog_model.sv
// Programming system model: drives entry, address, data, mode pins and pulses.
// Assumes the bench clock; port 0 pull-ups live in the testbench.
`timescale 1ns/10ps

module epv_prog_model (
	input  wire logic   clock,
	output logic        rst_pin,
	output logic        strobe,
	output logic        pulse_pin,
	output logic        supply,
	output logic [12:0] addr,
	output logic [7:0]  data,
	output logic [3:0]  pins
);
	initial begin
		rst_pin = 1'b0;
		strobe = 1'b1;
		pulse_pin = 1'b1;
		supply = 1'b0;
		addr = 13'h0000;
		data = 8'h00;
		pins = 4'h0;
	end

	// Strobe low while reset is held active
	task automatic enter();
		@(posedge clock);
		strobe <= 1'b0;
		rst_pin <= 1'b1;
	endtask

	// Levels held for a whole location
	task automatic setup(input logic [12:0] a, input logic [7:0] d, input logic [3:0] p,
		input logic s);
		@(posedge clock);
		addr <= a;
		data <= d;
		pins <= p;
		supply <= s;
	endtask

	// One low phase, then the minimum high phase
	task automatic pulse(input int low);
		@(posedge clock);
		pulse_pin <= 1'b0;
		repeat (low) @(posedge clock);
		pulse_pin <= 1'b1;
		repeat (200) @(posedge clock);
	endtask
endmodule

// ===== epv_pulse.sv
// Constants for the program/verify port and the programming pulse qualifier.
// Assumes the 20 MHz clock and a pulse pin already synchronous to it.
`timescale 1ns/10ps

package epv_pkg;
	localparam int unsigned CLK_HZ          = 20000000;
	localparam int unsigned ADDR_W          = 13;
	localparam int unsigned MEM_DEPTH       = 8192;
	localparam int unsigned KEY_DEPTH       = 32;
	localparam int unsigned KEY_W           = 5;
	localparam int unsigned PULSES_PER_LOC  = 25;
	localparam int unsigned PULSE_MIN_NS    = 90000;
	localparam int unsigned PULSE_MAX_NS    = 110000;
	localparam int unsigned GAP_MIN_NS      = 10000;
	localparam int unsigned PULSE_MIN_CYC   = (PULSE_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned PULSE_MAX_CYC   = (PULSE_MAX_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int unsigned GAP_MIN_CYC     = (GAP_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int unsigned CNT_W           = 12;
	localparam logic [12:0] SIG_MAKER_ADDR  = 13'h0030;
	localparam logic [12:0] SIG_DEVICE_ADDR = 13'h0031;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;
	localparam logic [1:0]  SEC_ERASED      = 2'h3;
	// Mode pins ordered upper_a, upper_b, lower_a, lower_b
	localparam logic [3:0]  PINS_SIGNATURE  = 4'h0;
	localparam logic [3:0]  PINS_PROG_CODE  = 4'hb;
	localparam logic [3:0]  PINS_VERIFY     = 4'h3;
	localparam logic [3:0]  PINS_PROG_KEY   = 4'ha;
	localparam logic [3:0]  PINS_PROG_SEC1  = 4'hf;
	localparam logic [3:0]  PINS_PROG_SEC2  = 4'hc;
	typedef enum logic [2:0] {
		EPV_MD_NONE, EPV_MD_SIG, EPV_MD_VERIFY, EPV_MD_CODE, EPV_MD_KEY, EPV_MD_SEC1, EPV_MD_SEC2
	} epv_mode_e;
endpackage

module epv_pulse (
	input  wire logic clock,
	input  wire logic srst,
	input  wire logic enable,
	input  wire logic restart,
	input  wire logic prog_pulse,
	output logic      seq_done
);
	logic [epv_pkg::CNT_W-1:0] width_q;
	logic [epv_pkg::CNT_W-1:0] width_d;
	logic [4:0]                count_q;
	logic [4:0]                count_d;
	logic                      prev_q;
	logic                      prev_d;
	logic                      done_q;
	logic                      done_d;
	logic                      rise;
	logic                      fall;

	assign seq_done = done_q;

	always_comb begin
		prev_d  = prog_pulse;
		rise    = prog_pulse & ~prev_q;
		fall    = ~prog_pulse & prev_q;
		done_d  = 1'b0;
		count_d = count_q;
		width_d = (rise | fall) ? '0 : width_q + ((&width_q) ? '0 : 12'h001);
		if (!enable || restart) begin
			count_d = '0;
		end else if (rise) begin
			// A low phase outside 90..110 us spoils the sequence
			if (width_q + 12'h001 >= 12'(epv_pkg::PULSE_MIN_CYC) &&
			    width_q + 12'h001 <= 12'(epv_pkg::PULSE_MAX_CYC)) begin
				if (count_q == 5'(epv_pkg::PULSES_PER_LOC - 1)) begin
					count_d = '0;
					done_d  = 1'b1;
				end else begin
					count_d = count_q + 5'h01;
				end
			end else begin
				count_d = '0;
			end
		end else if (fall && width_q + 12'h001 < 12'(epv_pkg::GAP_MIN_CYC)) begin
			count_d = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			width_q <= '0;
			count_q <= '0;
			prev_q  <= 1'b1;
			done_q  <= 1'b0;
		end else begin
			width_q <= width_d;
			count_q <= count_d;
			prev_q  <= prev_d;
			done_q  <= done_d;
		end
	end

	a_done_after_rise: assert property (@(posedge clock) disable iff (srst)
		seq_done |-> $past(prog_pulse) && !$past(prev_q))
		else $error("sequence end not on a rising edge");
	a_short_low_no_done: assert property (@(posedge clock) disable iff (srst)
		$rose(prog_pulse) && width_q < 12'(epv_pkg::PULSE_MIN_CYC - 1) |=> !seq_done)
		else $error("short pulse completed a sequence");
endmodule
